// File: hdl/mbia_pkg.sv
`default_nettype none
// ****************************************************************
// Shared constants for the microword branch and immediate ALU.
// ****************************************************************
package mbia_pkg;
  // Microword field positions.
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 27;
  localparam int FN_MSB = 26;
  localparam int FN_LSB = 23;
  localparam int CND_MSB = 22;
  localparam int CND_LSB = 18;
  localparam int SP_MSB = 17;
  localparam int SP_LSB = 12;
  localparam int DST_MSB = 11;
  localparam int DST_LSB = 8;
  localparam int SRC_MSB = 7;
  localparam int SRC_LSB = 4;
  // Data field of immediate words, in the low half.
  localparam int DAT_MSB = 15;
  localparam int DAT_LSB = 0;
  // Short target field of branch words.
  localparam int ADR_MSB = 5;
  localparam int ADR_LSB = 0;
  // Width of the short target field; a block is 64 words.
  localparam int SHORT_W = 6;
  // Opcode encodings (arbitrary assignment).
  localparam logic [4:0] IMM_OP = 5'h06;
  localparam logic [4:0] JUMP_IF_TRUE_OP = 5'h10;
  localparam logic [4:0] JUMP_IF_FALSE_OP = 5'h11;
  localparam logic [4:0] CALL_IF_TRUE_OP = 5'h12;
  localparam logic [4:0] CALL_IF_FALSE_OP = 5'h13;
  localparam logic [4:0] RETURN_IF_TRUE_OP = 5'h14;
  localparam logic [4:0] RETURN_IF_FALSE_OP = 5'h15;
  localparam logic [4:0] SPECIAL_IF_TRUE_OP = 5'h16;
  localparam logic [4:0] SPECIAL_IF_FALSE_OP = 5'h17;
  // Immediate ALU function codes.
  localparam logic [3:0] FN_ADD = 4'h0;
  localparam logic [3:0] FN_XNOR = 4'h1;
  localparam logic [3:0] FN_XOR = 4'h2;
  localparam logic [3:0] FN_AND = 4'h3;
  localparam logic [3:0] FN_NAND = 4'h4;
  localparam logic [3:0] FN_IOR = 4'h5;
  localparam logic [3:0] FN_INOR = 4'h6;
  // Values after reset.
  localparam logic [15:0] RESET_ADDR = 16'h0000;
  localparam logic [3:0] RESET_SP = 4'h0;
endpackage
`default_nettype wire

// File: hdl/mbia_core.sv
`default_nettype none
// ****************************************************************
// Microword decoder, immediate ALU and microsequencer.
// ****************************************************************
module mbia_core #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16,
  parameter int STACK_DEPTH = 16,
  parameter int SP_W = 4
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Microword from the control store.
  input wire logic [31:0] microword,
  input wire logic word_valid,
  // Condition inputs selected by the condition field.
  input wire logic [31:0] conditions,
  // Source register value read from the register store.
  input wire logic [DATA_W-1:0] source_data,
  // Microaddress towards the control store.
  output logic [ADDR_W-1:0] micro_addr,
  // Register store read select and write port.
  output logic [3:0] source_sel,
  output logic [3:0] dest_sel,
  output logic [DATA_W-1:0] dest_data,
  output logic dest_write,
  // Special microorder strobe.
  output logic [5:0] special_code,
  output logic special_fire,
  // Stack state.
  output logic [SP_W-1:0] stack_ptr
);

  // ****************************************************************
  // Decode
  // ****************************************************************

  // Fields of the current microword.
  logic [4:0] opcode;
  logic [3:0] func;
  logic [4:0] cond_sel;
  logic [DATA_W-1:0] literal;
  localparam int SHORT_W_L = mbia_pkg::SHORT_W;
  logic [SHORT_W_L-1:0] short_target_field;
  // Selected condition and taken flags.
  logic cond;
  logic polarity_ok;
  logic is_jump;
  logic is_call;
  logic is_ret;
  logic is_spec;
  logic take_jump;
  logic take_call;
  logic take_ret;
  // Sequencer next values.
  logic [ADDR_W-1:0] addr_plus1;
  logic [ADDR_W-1:0] block_target;
  logic [ADDR_W-1:0] next_addr;
  // Return stack storage.
  logic [ADDR_W-1:0] stack_mem [STACK_DEPTH];

  assign opcode = microword[mbia_pkg::OP_MSB:mbia_pkg::OP_LSB];
  assign func = microword[mbia_pkg::FN_MSB:mbia_pkg::FN_LSB];
  assign cond_sel = microword[mbia_pkg::CND_MSB:mbia_pkg::CND_LSB];
  // The literal sits in the data field of an immediate word.
  assign literal = DATA_W'(microword[mbia_pkg::DAT_MSB:mbia_pkg::DAT_LSB]);
  assign short_target_field = microword[mbia_pkg::ADR_MSB:mbia_pkg::ADR_LSB];
  assign cond = conditions[cond_sel];
  // Odd codes of each pair take the false polarity.
  assign polarity_ok = opcode[0] ? !cond : cond;
  assign is_jump = (opcode == mbia_pkg::JUMP_IF_TRUE_OP) ||
                   (opcode == mbia_pkg::JUMP_IF_FALSE_OP);
  assign is_call = (opcode == mbia_pkg::CALL_IF_TRUE_OP) ||
                   (opcode == mbia_pkg::CALL_IF_FALSE_OP);
  assign is_ret = (opcode == mbia_pkg::RETURN_IF_TRUE_OP) ||
                  (opcode == mbia_pkg::RETURN_IF_FALSE_OP);
  assign is_spec = (opcode == mbia_pkg::SPECIAL_IF_TRUE_OP) ||
                   (opcode == mbia_pkg::SPECIAL_IF_FALSE_OP);
  // Jumps, calls and returns take effect only on a polarity match.
  assign take_jump = word_valid && is_jump && polarity_ok;
  assign take_call = word_valid && is_call && polarity_ok;
  assign take_ret = word_valid && is_ret && polarity_ok;

  // ****************************************************************
  // Immediate ALU
  // ****************************************************************

  // Computes the immediate function result.
  function automatic logic [DATA_W-1:0] imm_alu(input logic [3:0] f,
      input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    unique case (f)
      mbia_pkg::FN_ADD: imm_alu = a + b;
      mbia_pkg::FN_XNOR: imm_alu = ~(a ^ b);
      mbia_pkg::FN_XOR: imm_alu = a ^ b;
      mbia_pkg::FN_AND: imm_alu = a & b;
      mbia_pkg::FN_NAND: imm_alu = ~(a & b);
      mbia_pkg::FN_IOR: imm_alu = a | b;
      mbia_pkg::FN_INOR: imm_alu = ~(a | b);
      default: imm_alu = a;
    endcase
  endfunction

  // Source select goes straight out so the store can read it.
  assign source_sel = microword[mbia_pkg::SRC_MSB:mbia_pkg::SRC_LSB];

  // Registers the destination write of an immediate word.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dest_write <= 1'b0;
      dest_sel <= 4'h0;
      dest_data <= '0;
    end else begin
      // Only valid immediate words with a known function write.
      dest_write <= word_valid && (opcode == mbia_pkg::IMM_OP) &&
                    (func <= mbia_pkg::FN_INOR);
      dest_sel <= microword[mbia_pkg::DST_MSB:mbia_pkg::DST_LSB];
      dest_data <= imm_alu(func, source_data, literal);
    end
  end

  // ****************************************************************
  // Conditional special
  // ****************************************************************

  // Fires the special field only on a polarity match.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      special_fire <= 1'b0;
      special_code <= 6'h00;
    end else begin
      special_fire <= word_valid && is_spec && polarity_ok;
      special_code <= microword[mbia_pkg::SP_MSB:mbia_pkg::SP_LSB];
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************

  assign addr_plus1 = ADDR_W'(micro_addr + 1'b1);
  // Short target replaces only the low bits of the next address.
  assign block_target = {addr_plus1[ADDR_W-1:SHORT_W_L], short_target_field};

  // Chooses the next microaddress.
  always_comb begin
    next_addr = micro_addr;
    if (word_valid) begin
      next_addr = addr_plus1;
    end
    if (take_jump || take_call) begin
      next_addr = block_target;
    end else if (take_ret) begin
      next_addr = stack_mem[SP_W'(stack_ptr - 1'b1)];
    end
  end

  // Holds the microaddress.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      micro_addr <= mbia_pkg::RESET_ADDR[ADDR_W-1:0];
    end else begin
      micro_addr <= next_addr;
    end
  end

  // Moves the stack pointer on calls and returns.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stack_ptr <= SP_W'(mbia_pkg::RESET_SP);
    end else if (take_call) begin
      stack_ptr <= SP_W'(stack_ptr + 1'b1);
    end else if (take_ret) begin
      stack_ptr <= SP_W'(stack_ptr - 1'b1);
    end
  end

  // Writes the return address on a taken call.
  always_ff @(posedge clock) begin
    if (take_call) begin
      stack_mem[stack_ptr] <= addr_plus1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  sequence s_call_taken;
    take_call;
  endsequence

  sequence s_pushed(logic [SP_W-1:0] p, logic [ADDR_W-1:0] a);
    (stack_ptr == SP_W'(p + 1'b1)) && (stack_mem[p] == a);
  endsequence

  a_call_push: assert property (@(posedge clock) disable iff (!rst_n)
    s_call_taken ##1 1'b1 |-> ##0 s_pushed($past(stack_ptr), $past(addr_plus1)))
    else $error("call did not push return address");

  a_branch_block: assert property (@(posedge clock) disable iff (!rst_n)
    (take_jump || take_call) |=> micro_addr[ADDR_W-1:SHORT_W_L] ==
      $past(addr_plus1[ADDR_W-1:SHORT_W_L]))
    else $error("branch left its block");

  a_jump_skip: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && is_jump && !polarity_ok) |=> micro_addr == $past(addr_plus1))
    else $error("untaken jump did not advance");

  a_call_skip: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && is_call && !polarity_ok) |=> stack_ptr == $past(stack_ptr))
    else $error("untaken call moved stack");

  a_ret_pop: assert property (@(posedge clock) disable iff (!rst_n)
    take_ret |=> (stack_ptr == SP_W'($past(stack_ptr) - 1'b1)) &&
      (micro_addr == stack_mem[stack_ptr]))
    else $error("return did not pop");

  a_ret_cond: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && is_ret && (opcode[0] == cond)) |=> micro_addr == $past(addr_plus1))
    else $error("return taken on wrong polarity");

  a_spec_gate: assert property (@(posedge clock) disable iff (!rst_n)
    special_fire |-> $past(is_spec && word_valid && (opcode[0] != cond)))
    else $error("special fired on wrong polarity");

  a_imm_add: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && opcode == mbia_pkg::IMM_OP && func == mbia_pkg::FN_ADD) |=>
      dest_write && (dest_data == DATA_W'($past(source_data) + $past(literal))))
    else $error("immediate add wrong");

  a_imm_xnor: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && opcode == mbia_pkg::IMM_OP && func == mbia_pkg::FN_XNOR) |=>
      dest_data == ~($past(source_data) ^ $past(literal)))
    else $error("immediate xnor wrong");

  a_imm_nand: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && opcode == mbia_pkg::IMM_OP && func == mbia_pkg::FN_NAND) |=>
      dest_data == ~($past(source_data) & $past(literal)))
    else $error("immediate nand wrong");

  a_no_write: assert property (@(posedge clock) disable iff (!rst_n)
    (opcode != mbia_pkg::IMM_OP) |=> !dest_write)
    else $error("write without immediate opcode");

  a_imm_xor: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && opcode == mbia_pkg::IMM_OP && func == mbia_pkg::FN_XOR) |=>
      dest_write && (dest_data == ($past(source_data) ^ $past(literal))))
    else $error("immediate xor wrong");

  a_imm_and: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && opcode == mbia_pkg::IMM_OP && func == mbia_pkg::FN_AND) |=>
      dest_write && (dest_data == ($past(source_data) & $past(literal))))
    else $error("immediate and wrong");

  a_imm_ior: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && opcode == mbia_pkg::IMM_OP && func == mbia_pkg::FN_IOR) |=>
      dest_write && (dest_data == ($past(source_data) | $past(literal))))
    else $error("immediate or wrong");

  a_imm_inor: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && opcode == mbia_pkg::IMM_OP && func == mbia_pkg::FN_INOR) |=>
      dest_write && (dest_data == ~($past(source_data) | $past(literal))))
    else $error("immediate nor wrong");

  a_imm_refuse: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && opcode == mbia_pkg::IMM_OP && func > mbia_pkg::FN_INOR) |=> !dest_write)
    else $error("unknown immediate function wrote");

  a_jump_take: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && is_jump && (opcode[0] != cond)) |=> micro_addr ==
      {$past(addr_plus1[ADDR_W-1:SHORT_W_L]), $past(microword[mbia_pkg::ADR_MSB:mbia_pkg::ADR_LSB])})
    else $error("taken jump missed its target");

  a_call_enter: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && is_call && (opcode[0] != cond)) |=>
      (micro_addr[SHORT_W_L-1:0] == $past(microword[mbia_pkg::ADR_MSB:mbia_pkg::ADR_LSB])) &&
      (stack_ptr == SP_W'($past(stack_ptr) + 1'b1)))
    else $error("taken call missed its target");

  a_ret_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && is_ret && (opcode[0] == cond)) |=> stack_ptr == $past(stack_ptr))
    else $error("untaken return moved stack");

  a_spec_fire: assert property (@(posedge clock) disable iff (!rst_n)
    (word_valid && is_spec && (opcode[0] != cond)) |=>
      special_fire && (special_code == $past(microword[mbia_pkg::SP_MSB:mbia_pkg::SP_LSB])))
    else $error("matching special did not fire");

endmodule
`default_nettype wire

// File: bench/mbia_store.sv
`default_nettype none
// ****************************************************************
// Control store model that feeds microwords to the sequencer.
// ****************************************************************
module mbia_store (
  // Address from the sequencer.
  input wire logic [15:0] micro_addr,
  // Stall request from the bench.
  input wire logic stall,
  // Microword towards the sequencer.
  output logic [31:0] microword,
  output logic word_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  // Word storage, loaded by the bench.
  logic [31:0] mem [0:1023];
  // Clear the store so unused places decode as plain advances.
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 32'h00000000;
    end
  end
  // A stalled store shows the inverted word, so stale data never looks usable.
  assign word_valid = ~stall;
  assign microword = stall ? ~mem[micro_addr[9:0]] : mem[micro_addr[9:0]];
endmodule
`default_nettype wire

// File: bench/microword_branch_and_immediate_alu_tb_top.sv
`default_nettype none
// ****************************************************************
// Self-checking bench for the decoder, immediate ALU and sequencer.
// ****************************************************************
module microword_branch_and_immediate_alu_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Clock, reset and stimulus.
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic stall = 1'b0;
  logic [31:0] conditions = 32'h00000000;
  logic [15:0] regs [0:15];
  // Store and design outputs.
  logic [31:0] microword;
  logic word_valid;
  logic [15:0] micro_addr;
  logic [3:0] source_sel;
  logic [3:0] dest_sel;
  logic [15:0] dest_data;
  logic dest_write;
  logic [5:0] special_code;
  logic special_fire;
  logic [3:0] stack_ptr;
  wire logic [15:0] source_data;
  int n_fail = 0;
  int check_count = 0;
  // The register store answers in the same cycle.
  assign source_data = regs[source_sel];
  always #4 clock = ~clock;
  mbia_store store (.micro_addr(micro_addr), .stall(stall), .microword(microword),
    .word_valid(word_valid));
  mbia_core dut (.clock(clock), .rst_n(rst_n), .microword(microword),
    .word_valid(word_valid), .conditions(conditions), .source_data(source_data),
    .micro_addr(micro_addr), .source_sel(source_sel), .dest_sel(dest_sel),
    .dest_data(dest_data), .dest_write(dest_write), .special_code(special_code),
    .special_fire(special_fire), .stack_ptr(stack_ptr));
  // Compare one value and count it.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Branch-type word with condition index 5 and a short target.
  function automatic logic [31:0] br(input logic [4:0] op, input logic [5:0] tgt);
    return {op, 4'h0, 5'h05, 12'h000, tgt};
  endfunction
  // Load a word at the current address, run one edge, check sequencing.
  task automatic exec(input logic [31:0] word, input logic cnd, input logic [15:0] ea,
      input logic [3:0] esp, input logic ewr, input logic efire);
    store.mem[micro_addr[9:0]] = word;
    conditions = cnd ? 32'h00000020 : 32'hFFFFFFDF;
    @(posedge clock);
    #1;
    chk("micro_addr", ea, micro_addr);
    chk("stack_ptr", {12'h000, esp}, {12'h000, stack_ptr});
    chk("dest_write", {15'h0000, ewr}, {15'h0000, dest_write});
    chk("special_fire", {15'h0000, efire}, {15'h0000, special_fire});
  endtask
  // Every immediate function plus one unused code, back to back.
  task automatic alu_scenario();
    logic [15:0] a;
    logic [15:0] l;
    logic [15:0] e;
    l = 16'h3C5A;
    a = regs[4'h5];
    for (int f = 0; f < 8; f++) begin
      case (f)
        0: e = a + l;
        1: e = ~(l ^ a);
        2: e = a ^ l;
        3: e = a & l;
        4: e = ~(a & l);
        5: e = a | l;
        default: e = ~(a | l);
      endcase
      exec({mbia_pkg::IMM_OP, f[3:0], 7'h00, l}, 1'b0, micro_addr + 16'h0001, 4'h0,
        f < 7, 1'b0);
      if (f < 7) begin
        chk("dest_data", e, dest_data);
        chk("dest_sel", 16'h000C, {12'h000, dest_sel});
      end
    end
  endtask
  // Jumps at block edges, taken and not taken, both polarities.
  task automatic jump_scenario();
    exec(br(mbia_pkg::JUMP_IF_TRUE_OP, 6'h3F), 1'b1, 16'h003F, 4'h0, 1'b0, 1'b0);
    exec(br(mbia_pkg::JUMP_IF_FALSE_OP, 6'h3F), 1'b0, 16'h007F, 4'h0, 1'b0, 1'b0);
    exec(br(mbia_pkg::JUMP_IF_TRUE_OP, 6'h05), 1'b0, 16'h0080, 4'h0, 1'b0, 1'b0);
    exec(br(mbia_pkg::JUMP_IF_FALSE_OP, 6'h05), 1'b1, 16'h0081, 4'h0, 1'b0, 1'b0);
  endtask
  // Nested calls, refused returns, then two taken returns.
  task automatic call_scenario();
    exec(br(mbia_pkg::CALL_IF_FALSE_OP, 6'h10), 1'b1, 16'h0082, 4'h0, 1'b0, 1'b0);
    exec(br(mbia_pkg::CALL_IF_TRUE_OP, 6'h3F), 1'b1, 16'h00BF, 4'h1, 1'b0, 1'b0);
    exec(br(mbia_pkg::CALL_IF_FALSE_OP, 6'h00), 1'b0, 16'h00C0, 4'h2, 1'b0, 1'b0);
    exec(br(mbia_pkg::RETURN_IF_TRUE_OP, 6'h00), 1'b0, 16'h00C1, 4'h2, 1'b0, 1'b0);
    exec(br(mbia_pkg::RETURN_IF_FALSE_OP, 6'h00), 1'b1, 16'h00C2, 4'h2, 1'b0, 1'b0);
    exec(br(mbia_pkg::RETURN_IF_FALSE_OP, 6'h00), 1'b0, 16'h00C0, 4'h1, 1'b0, 1'b0);
    exec(br(mbia_pkg::RETURN_IF_TRUE_OP, 6'h00), 1'b1, 16'h0083, 4'h0, 1'b0, 1'b0);
  endtask
  // Conditional specials in all four polarity cases.
  task automatic special_scenario();
    logic [31:0] wt;
    logic [31:0] wf;
    // Code 2A is neither a shift, a rotate nor the load-Q special.
    wt = {mbia_pkg::SPECIAL_IF_TRUE_OP, 4'h0, 5'h05, 6'h2A, 12'h000};
    wf = {mbia_pkg::SPECIAL_IF_FALSE_OP, 4'h0, 5'h05, 6'h2A, 12'h000};
    exec(wt, 1'b1, 16'h0084, 4'h0, 1'b0, 1'b1);
    chk("special_code", 16'h002A, {10'h000, special_code});
    exec(wf, 1'b1, 16'h0085, 4'h0, 1'b0, 1'b0);
    exec(wf, 1'b0, 16'h0086, 4'h0, 1'b0, 1'b1);
    exec(wt, 1'b0, 16'h0087, 4'h0, 1'b0, 1'b0);
  endtask
  // An immediate word held off by a stall must do nothing until valid.
  task automatic stall_scenario();
    store.mem[micro_addr[9:0]] = {mbia_pkg::IMM_OP, 4'h0, 7'h00, 16'h3C5A};
    stall = 1'b1;
    @(posedge clock);
    #1;
    chk("micro_addr", 16'h0087, micro_addr);
    chk("dest_write", 16'h0000, {15'h0000, dest_write});
    stall = 1'b0;
    exec({mbia_pkg::IMM_OP, 4'h0, 7'h00, 16'h3C5A}, 1'b0, 16'h0088, 4'h0, 1'b1, 1'b0);
    // Register five holds 5555, so the held-off add must still produce 91AF.
    chk("dest_data", 16'h91AF, dest_data);
  endtask
  // Main sequence: reset for ten cycles, then every scenario in turn.
  initial begin
    for (int i = 0; i < 16; i++) begin
      regs[i] = 16'h1111 * i[15:0];
    end
    repeat (10) @(posedge clock);
    #1;
    rst_n = 1'b1;
    alu_scenario();
    jump_scenario();
    call_scenario();
    special_scenario();
    stall_scenario();
    results();
  end
endmodule
`default_nettype wire
